// [spd_pkg.sv]
// constants shared by the standby power-down control block
// assumes a single 40 MHz core clock
package spd_pkg;

	// ----------------------------------------------------------------
	// command opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_STANDBY_A = 8'hE2;
	localparam logic [7:0] OPC_STANDBY_B = 8'h96;
	localparam logic [7:0] OPC_STANDBY_NOW_A = 8'hE0;
	localparam logic [7:0] OPC_STANDBY_NOW_B = 8'h94;

	// ----------------------------------------------------------------
	// timeout code encoding
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_DISABLE = 8'h00;
	localparam logic [7:0] CODE_FIVE_SEC_MAX = 8'hF0;
	localparam logic [7:0] CODE_HALF_HOUR_MAX = 8'hFB;
	localparam logic [7:0] CODE_21_MIN = 8'hFC;
	localparam logic [7:0] CODE_8_HOUR = 8'hFD;
	localparam logic [7:0] CODE_ABORT = 8'hFE;
	localparam logic [7:0] CODE_21_MIN_15_SEC = 8'hFF;

	// ----------------------------------------------------------------
	// intervals, counted in units of five seconds
	// ----------------------------------------------------------------
	localparam int UNIT_SECONDS = 5;
	localparam int CLK_HZ = 40000000;
	localparam int UNIT_CYCLES = UNIT_SECONDS * CLK_HZ;
	localparam int UNITS_W = 13;
	localparam int PRESCALE_W = 28;
	localparam logic [12:0] UNITS_HALF_HOUR = 13'h0168;
	localparam logic [12:0] UNITS_21_MIN = 13'h00FC;
	localparam logic [12:0] UNITS_8_HOUR = 13'h1680;
	localparam logic [12:0] UNITS_21_MIN_15_SEC = 13'h00FF;
	localparam logic [12:0] UNITS_ONE = 13'h0001;

	// ----------------------------------------------------------------
	// power states, gray coded along active -> down -> standby -> up
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SPD_ACTIVE = 2'h0,
		SPD_SPIN_DOWN = 2'h1,
		SPD_STANDBY = 2'h3,
		SPD_SPIN_UP = 2'h2
	} spd_state_e;

endpackage

// [spd_spindle_model.sv]
// behavioural spindle: stops or reaches speed some cycles after a request
// assumes requests stay high until the matching level is reported
`timescale 1ns/1ps
`default_nettype none

module spd_spindle_model (
	// clock, reset and pace select
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic slow,
	// requests from the block
	input wire logic spinDownReq,
	input wire logic spinUpReq,
	// levels back to the block
	output logic spindleStopped,
	output logic spindleAtSpeed
);
	int cnt;

	// powered up spinning, since the block assumes that after reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt <= 0;
			spindleStopped <= 1'b0;
			spindleAtSpeed <= 1'b1;
		end else if ((spinDownReq && !spindleStopped) || (spinUpReq && !spindleAtSpeed)) begin
			cnt <= cnt + 1;
			if (cnt >= (slow ? 20 : 3)) begin
				cnt <= 0;
				spindleStopped <= spinDownReq;
				spindleAtSpeed <= !spinDownReq;
			end
		end
	end
endmodule // spd_spindle_model

`default_nettype wire

// [spd_standby_ctrl.sv]
// standby / standby-immediate command handling and auto power-down timer
// assumes the task-file front end hands over decoded commands as pulses
// and that the spindle driver reports its state on asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module spd_standby_ctrl
	import spd_pkg::*;
#(
	parameter int UNIT_CYCLES_P = UNIT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// command hand-over from the task file
	input wire logic cmdValid,
	input wire logic [7:0] cmdOpcode,
	input wire logic [7:0] cmdSectorCount,
	input wire logic hostAccess,
	// media command hand-over
	input wire logic mediaReq,
	output logic mediaGo,
	// spindle driver
	input wire logic spindleStopped,
	input wire logic spindleAtSpeed,
	output logic spinDownReq,
	output logic spinUpReq,
	// status toward the task file
	output logic statusBusy,
	output logic statusReady,
	output logic statusError,
	output logic errorAbort,
	output logic cmdDone,
	output logic inStandby
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		spd_state_e st;
		logic [2:0] stoppedSync;
		logic [2:0] speedSync;
		logic stoppedLvl;
		logic speedLvl;
		logic timerEn;
		logic [12:0] intervalUnits;
		logic [12:0] remainUnits;
		logic [27:0] prescale;
		logic cmdPending;
		logic mediaPending;
		logic mediaGo;
		logic busy;
		logic ready;
		logic err;
		logic abort;
		logic done;
		logic downReq;
		logic upReq;
		logic standby;
	} spd_regs_s;

	spd_regs_s regs_reg;
	spd_regs_s regs_next;

	logic [12:0] decUnits;
	logic decOff;
	logic decAbort;
	logic isTimed;
	logic isNow;
	logic unitTick;

	spd_timeout_decode u_decode (
		.timeoutCode(cmdSectorCount),
		.intervalUnits(decUnits),
		.timerOff(decOff),
		.codeAbort(decAbort)
	);

	assign isTimed = (cmdOpcode == OPC_STANDBY_A) || (cmdOpcode == OPC_STANDBY_B);
	assign isNow = (cmdOpcode == OPC_STANDBY_NOW_A) || (cmdOpcode == OPC_STANDBY_NOW_B);
	assign unitTick = regs_reg.prescale == PRESCALE_W'(UNIT_CYCLES_P - 1);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		regs_next = regs_reg;
		regs_next.done = 1'b0;
		regs_next.mediaGo = 1'b0;

		// three-stage sync; a change counts once stages two and three agree
		regs_next.stoppedSync = {regs_reg.stoppedSync[1:0], spindleStopped};
		regs_next.speedSync = {regs_reg.speedSync[1:0], spindleAtSpeed};
		if (regs_reg.stoppedSync[1] == regs_reg.stoppedSync[2]) begin
			regs_next.stoppedLvl = regs_reg.stoppedSync[2];
		end
		if (regs_reg.speedSync[1] == regs_reg.speedSync[2]) begin
			regs_next.speedLvl = regs_reg.speedSync[2];
		end

		// idle timer: runs only in active state, restarts on host access
		if (regs_reg.st == SPD_ACTIVE && regs_reg.timerEn) begin
			regs_next.prescale = unitTick ? '0 : regs_reg.prescale + 28'h0000001;
			if (unitTick) begin
				regs_next.remainUnits = regs_reg.remainUnits - UNITS_ONE;
			end
			if (unitTick && regs_reg.remainUnits <= UNITS_ONE) begin
				regs_next.st = SPD_SPIN_DOWN;
			end
		end else begin
			regs_next.prescale = '0;
			regs_next.remainUnits = regs_reg.intervalUnits;
		end
		if (hostAccess || mediaReq) begin
			regs_next.prescale = '0;
			regs_next.remainUnits = regs_reg.intervalUnits;
		end

		// media commands wait for a spinning spindle
		if (mediaReq) begin
			if (regs_reg.st == SPD_ACTIVE) begin
				regs_next.mediaGo = 1'b1;
			end else begin
				regs_next.mediaPending = 1'b1;
			end
		end

		unique case (regs_reg.st)
			SPD_ACTIVE: begin
			end
			SPD_SPIN_DOWN: begin
				// spindle stop only; the interface side keeps running
				if (regs_reg.stoppedLvl) begin
					regs_next.st = SPD_STANDBY;
				end
			end
			SPD_STANDBY: begin
				if (regs_reg.mediaPending || mediaReq) begin
					regs_next.st = SPD_SPIN_UP;
				end
			end
			SPD_SPIN_UP: begin
				if (regs_reg.speedLvl) begin
					regs_next.st = SPD_ACTIVE;
					regs_next.mediaPending = 1'b0;
					regs_next.mediaGo = regs_reg.mediaPending;
				end
			end
		endcase

		// a command waiting on spin-down completes once the spindle is still
		if (regs_reg.cmdPending && regs_next.st == SPD_STANDBY) begin
			regs_next.cmdPending = 1'b0;
			regs_next.busy = 1'b0;
			regs_next.ready = 1'b1;
			regs_next.done = 1'b1;
		end

		// host relies on sector count being valid with the opcode
		if (cmdValid && !regs_reg.busy && (isTimed || isNow)) begin
			regs_next.err = 1'b0;
			regs_next.abort = 1'b0;
			if (isTimed && decAbort) begin
				regs_next.err = 1'b1;
				regs_next.abort = 1'b1;
				regs_next.ready = 1'b1;
				regs_next.done = 1'b1;
			end else begin
				if (isTimed) begin
					// only the timed opcode touches the stored setting
					regs_next.timerEn = !decOff;
					regs_next.intervalUnits = decUnits;
					if (!decOff) begin
						regs_next.timerEn = 1'b1;
					end
				end
				if (regs_reg.stoppedLvl) begin
					// already still: no spin-down, finish now
					regs_next.st = SPD_STANDBY;
					regs_next.ready = 1'b1;
					regs_next.done = 1'b1;
				end else begin
					regs_next.st = SPD_SPIN_DOWN;
					regs_next.busy = 1'b1;
					regs_next.ready = 1'b0;
					regs_next.cmdPending = 1'b1;
				end
			end
		end

		// state levels kept in flops of their own so the pins never carry a decode glitch
		regs_next.downReq = regs_next.st == SPD_SPIN_DOWN;
		regs_next.upReq = regs_next.st == SPD_SPIN_UP;
		regs_next.standby = regs_next.st == SPD_STANDBY;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			regs_reg <= '{st: SPD_ACTIVE, ready: 1'b1, intervalUnits: UNITS_ONE,
				remainUnits: UNITS_ONE, default: '0};
		end else begin
			regs_reg <= regs_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	assign mediaGo = regs_reg.mediaGo;
	assign spinDownReq = regs_reg.downReq;
	assign spinUpReq = regs_reg.upReq;
	assign statusBusy = regs_reg.busy;
	assign statusReady = regs_reg.ready;
	assign statusError = regs_reg.err;
	assign errorAbort = regs_reg.abort;
	assign cmdDone = regs_reg.done;
	assign inStandby = regs_reg.standby;

endmodule // spd_standby_ctrl
`default_nettype wire

// [spd_standby_props.sv]
// assertions on the ports of the standby control block
// assumes a bind from the testbench top and one clock domain
`timescale 1ns/1ps
`default_nettype none

module spd_standby_props
	import spd_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// command and media side
	input wire logic cmdValid,
	input wire logic mediaReq,
	input wire logic [7:0] cmdOpcode,
	input wire logic [7:0] cmdSectorCount,
	// outputs
	input wire logic mediaGo,
	input wire logic spinDownReq,
	input wire logic spinUpReq,
	input wire logic statusBusy,
	input wire logic statusReady,
	input wire logic statusError,
	input wire logic errorAbort,
	input wire logic cmdDone,
	input wire logic inStandby
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	wire logic take = cmdValid && !statusBusy;
	wire logic imm = take && (cmdOpcode == OPC_STANDBY_NOW_A || cmdOpcode == OPC_STANDBY_NOW_B);
	wire logic tmd = take && (cmdOpcode == OPC_STANDBY_A || cmdOpcode == OPC_STANDBY_B);

	a_done_ready: assert property (cmdDone |-> !statusBusy && statusReady)
		else $error("done while busy or not ready");
	a_busy_ready: assert property (statusBusy |-> !statusReady)
		else $error("busy and ready together");
	a_abort_flags: assert property (tmd && cmdSectorCount == CODE_ABORT
		|=> cmdDone && statusError && errorAbort && !spinDownReq)
		else $error("abort code not refused");
	a_skip_down: assert property (imm && inStandby |=> cmdDone && !spinDownReq)
		else $error("spin-down repeated when stopped");
	a_spin_down: assert property ((imm || tmd && cmdSectorCount != CODE_ABORT) && !inStandby
		&& !spinDownReq && !spinUpReq |=> spinDownReq && statusBusy)
		else $error("standby did not stop spindle");
	a_down_ends: assert property ($fell(spinDownReq) |-> inStandby)
		else $error("spin-down ended outside standby");
	a_media_go: assert property (mediaReq && !inStandby && !spinDownReq && !spinUpReq
		|=> mediaGo)
		else $error("media held while active");
	a_up_media: assert property (inStandby && mediaReq |=> spinUpReq)
		else $error("media request did not spin up");
	a_no_go: assert property (inStandby |-> !mediaGo)
		else $error("media go while in standby");
	a_go_speed: assert property (spinUpReq |-> !mediaGo)
		else $error("media go before spindle at speed");
	a_err_hold: assert property (statusError && !take |=> statusError)
		else $error("error dropped without a new command");
endmodule // spd_standby_props

`default_nettype wire

// [spd_timeout_decode.sv]
// decodes the 8-bit timeout code into a count of five-second units
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none

module spd_timeout_decode
	import spd_pkg::*;
(
	// code in
	input wire logic [7:0] timeoutCode,
	// decoded result
	output logic [12:0] intervalUnits,
	output logic timerOff,
	output logic codeAbort
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		intervalUnits = UNITS_ONE;
		timerOff = 1'b0;
		codeAbort = 1'b0;
		if (timeoutCode == CODE_DISABLE) begin
			timerOff = 1'b1;
		end else if (timeoutCode <= CODE_FIVE_SEC_MAX) begin
			intervalUnits = {5'h00, timeoutCode};
		end else if (timeoutCode <= CODE_HALF_HOUR_MAX) begin
			intervalUnits = 13'(({5'h00, timeoutCode} - {5'h00, CODE_FIVE_SEC_MAX})
				* UNITS_HALF_HOUR);
		end else if (timeoutCode == CODE_21_MIN) begin
			intervalUnits = UNITS_21_MIN;
		end else if (timeoutCode == CODE_8_HOUR) begin
			intervalUnits = UNITS_8_HOUR;
		end else if (timeoutCode == CODE_ABORT) begin
			codeAbort = 1'b1;
		end else begin
			intervalUnits = UNITS_21_MIN_15_SEC;
		end
	end

endmodule // spd_timeout_decode
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the standby control block and its spindle
// assumes a unit of 4 cycles so that long intervals stay short
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import spd_pkg::*;
	logic sys_clk, reset, cmdValid, hostAccess, mediaReq, slow;
	logic [7:0] cmdOpcode, cmdSectorCount;
	logic mediaGo, spindleStopped, spindleAtSpeed, spinDownReq, spinUpReq;
	logic statusBusy, statusReady, statusError, errorAbort, cmdDone, inStandby;
	int num_errors = 0;
	int tests_run = 0;
	int n;
	int codes[7] = '{1, 3, 240, 241, 252, 253, 255};
	int units[7] = '{1, 3, 240, 360, 252, 5760, 255};

	spd_standby_ctrl #(.UNIT_CYCLES_P(4)) dut (
		.sys_clk(sys_clk),
		.reset(reset),
		.cmdValid(cmdValid),
		.cmdOpcode(cmdOpcode),
		.cmdSectorCount(cmdSectorCount),
		.hostAccess(hostAccess),
		.mediaReq(mediaReq),
		.mediaGo(mediaGo),
		.spindleStopped(spindleStopped),
		.spindleAtSpeed(spindleAtSpeed),
		.spinDownReq(spinDownReq),
		.spinUpReq(spinUpReq),
		.statusBusy(statusBusy),
		.statusReady(statusReady),
		.statusError(statusError),
		.errorAbort(errorAbort),
		.cmdDone(cmdDone),
		.inStandby(inStandby)
	);
	spd_spindle_model model (
		.sys_clk(sys_clk),
		.reset(reset),
		.slow(slow),
		.spinDownReq(spinDownReq),
		.spinUpReq(spinUpReq),
		.spindleStopped(spindleStopped),
		.spindleAtSpeed(spindleAtSpeed)
	);

	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] sc);
		@(posedge sys_clk);
		cmdOpcode <= op;
		cmdSectorCount <= sc;
		cmdValid <= 1'b1;
		@(posedge sys_clk);
		cmdValid <= 1'b0;
		#1;
		for (n = 0; cmdDone !== 1'b1 && n < 200; n++) tick(1);
		chk(n < 200 && statusBusy === 1'b0 && statusReady === 1'b1, "command did not complete");
	endtask

	task automatic wake;
		@(posedge sys_clk);
		mediaReq <= 1'b1;
		@(posedge sys_clk);
		mediaReq <= 1'b0;
		#1;
		for (n = 0; mediaGo !== 1'b1 && n < 200; n++) tick(1);
		chk(mediaGo === 1'b1 && inStandby === 1'b0, "no media go after spin-up");
	endtask

	// measures idle time to the automatic spin-down, then waits for standby
	task automatic expire(input int u);
		for (n = 0; spinDownReq !== 1'b1 && n < u * 4 + 8; n++) tick(1);
		chk(n >= u * 4 - 2 && n <= u * 4 + 4, "wrong idle interval");
		for (n = 0; inStandby !== 1'b1 && n < 200; n++) tick(1);
		chk(n < 200, "no standby after idle spin-down");
	endtask

	// mid-run reset must drop the error and the armed 255 setting
	task automatic t_reset;
		cmd(OPC_STANDBY_A, CODE_ABORT);
		chk(statusError === 1'b1, "abort before reset");
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk(statusError === 1'b0 && errorAbort === 1'b0 && statusReady === 1'b1
			&& statusBusy === 1'b0 && inStandby === 1'b0, "reset values");
		tick(1040);
		chk(spinDownReq === 1'b0 && inStandby === 1'b0, "timer still armed after reset");
	endtask

	task automatic t_immediate;
		cmd(OPC_STANDBY_NOW_A, 8'h00);
		chk(inStandby === 1'b1 && statusReady === 1'b1 && spinDownReq === 1'b0, "no standby");
		cmd(OPC_STANDBY_NOW_B, 8'h00);
		chk(n <= 1 && inStandby === 1'b1, "spin-down not skipped");
		wake;
	endtask

	task automatic t_abort;
		cmd(OPC_STANDBY_A, CODE_ABORT);
		chk(n <= 1 && statusError === 1'b1 && errorAbort === 1'b1 && inStandby === 1'b0, "abort");
	endtask

	task automatic t_access;
		cmd(OPC_STANDBY_A, 8'h05);
		wake;
		repeat (10) begin
			@(posedge sys_clk);
			hostAccess <= 1'b1;
			@(posedge sys_clk);
			hostAccess <= 1'b0;
			tick(2);
		end
		chk(spinDownReq === 1'b0 && inStandby === 1'b0, "access did not restart timer");
		expire(5);
		cmd(OPC_STANDBY_NOW_A, 8'h00);
		wake;
		expire(5);
		wake;
	endtask

	task automatic t_disabled;
		cmd(OPC_STANDBY_B, CODE_DISABLE);
		wake;
		tick(100);
		chk(spinDownReq === 1'b0 && inStandby === 1'b0, "code zero left timer on");
	endtask

	task automatic t_timer(input logic [7:0] code, input int u);
		cmd(OPC_STANDBY_B, code);
		chk(statusError === 1'b0 && inStandby === 1'b1, "timed standby");
		tick(40);
		chk(inStandby === 1'b1 && spinUpReq === 1'b0, "timer ran in standby");
		wake;
		expire(u);
		wake;
	endtask

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// whole run is near 30k cycles
	initial begin
		#(100000 * 25);
		num_errors++;
		end_sim;
	end

	initial begin
		reset = 1'b1;
		cmdValid = 1'b0;
		hostAccess = 1'b0;
		mediaReq = 1'b0;
		slow = 1'b0;
		cmdOpcode = 8'h00;
		cmdSectorCount = 8'h00;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		tick(4);
		t_immediate;
		t_abort;
		t_access;
		t_disabled;
		slow = 1'b1;
		foreach (codes[i]) t_timer(8'(codes[i]), units[i]);
		t_reset;
		end_sim;
	end
endmodule // tb_top

bind spd_standby_ctrl spd_standby_props u_props (
	.sys_clk(sys_clk),
	.reset(reset),
	.cmdValid(cmdValid),
	.mediaReq(mediaReq),
	.cmdOpcode(cmdOpcode),
	.cmdSectorCount(cmdSectorCount),
	.mediaGo(mediaGo),
	.spinDownReq(spinDownReq),
	.spinUpReq(spinUpReq),
	.statusBusy(statusBusy),
	.statusReady(statusReady),
	.statusError(statusError),
	.errorAbort(errorAbort),
	.cmdDone(cmdDone),
	.inStandby(inStandby)
);

`default_nettype wire
